// File: rtl/cer_top.sv
// crc engine with its axi4-lite register bank and dma request
// assumes one clock, synchronous active-low reset, one write and one read at a time
//
// Notes on behaviour
// - output byte swap set presents the result with bytes reversed.
// - input byte swap clear consumes low byte first, set high byte first.
// - bit order clear feeds lsb first, set feeds msb first (reflected).
// - with dma mode and enable set, request data whenever busy is low and no data input write is held.
// - byte write to the data input folds one byte; location write-only.
// - halfword write folds one halfword using the configured ordering.
// - word write folds a full word; access width sets bit count.
// - result register loads the start remainder, holds running result.
// - control fields reset to zero; reserved bits read zero.
// - busy stays high while folding and clears once the result is valid.
// - result read is raw, reflected, swapped, or reflected then swapped.
`timescale 1ns/1ns
`default_nettype none

module cer_top (
	input wire logic aclk, // bus clock, 50 MHz
	input wire logic aresetn, // synchronous reset, active low
	input wire cer_pkg::cer_addr_t s_axi_awaddr, // write address
	input wire logic [2:0] s_axi_awprot, // unused
	input wire logic s_axi_awvalid, // write address valid
	output logic s_axi_awready, // write address ready
	input wire cer_pkg::cer_word_t s_axi_wdata, // write data
	input wire cer_pkg::cer_strb_t s_axi_wstrb, // byte lanes
	input wire logic s_axi_wvalid, // write data valid
	output logic s_axi_wready, // write data ready
	output cer_pkg::cer_resp_t s_axi_bresp, // write response
	output logic s_axi_bvalid, // write response valid
	input wire logic s_axi_bready, // write response ready
	input wire cer_pkg::cer_addr_t s_axi_araddr, // read address
	input wire logic [2:0] s_axi_arprot, // unused
	input wire logic s_axi_arvalid, // read address valid
	output logic s_axi_arready, // read address ready
	output cer_pkg::cer_word_t s_axi_rdata, // read data
	output cer_pkg::cer_resp_t s_axi_rresp, // read response
	output logic s_axi_rvalid, // read data valid
	input wire logic s_axi_rready, // read data ready
	output logic dma_req, // level, asks the dma for the next word
	output logic crc_busy // mirror of the busy flag
);
	import cer_pkg::*;

	// ---------------------------------------------------------------
	// decoding helpers
	// ---------------------------------------------------------------
	function automatic logic cer_addr_ok(input cer_addr_t a);
		return a[1:0] == 2'h0;
	endfunction : cer_addr_ok

	// access width from the byte strobes; odd patterns fold nothing
	function automatic logic [5:0] cer_strobe_bits(input cer_strb_t s);
		case (s)
			4'h1, 4'h2, 4'h4, 4'h8: return CER_BITS_BYTE;
			4'h3, 4'hc: return CER_BITS_HALF;
			4'hf: return CER_BITS_WORD;
			default: return CER_BITS_NONE;
		endcase
	endfunction : cer_strobe_bits

	// right-justify the active lanes
	function automatic cer_word_t cer_lane_data(input cer_word_t d, input cer_strb_t s);
		case (s)
			4'h2: return {24'h000000, d[15:8]};
			4'h4: return {24'h000000, d[23:16]};
			4'h8: return {24'h000000, d[31:24]};
			4'hc: return {16'h0000, d[31:16]};
			default: return d;
		endcase
	endfunction : cer_lane_data

	// serial order: bit 0 of the result is fed first
	function automatic cer_word_t cer_order_bits(input cer_word_t d, input logic [5:0] nbits,
			input logic swap_in, input logic msb_first);
		cer_word_t r;
		int nb;
		int lane;
		int bsel;
		r = 32'h00000000;
		nb = int'(nbits) / 8;
		for (int k = 0; k < 4; k++) begin
			for (int j = 0; j < 8; j++) begin
				if (k < nb) begin
					lane = swap_in ? (nb - 1 - k) : k;
					bsel = msb_first ? (7 - j) : j;
					r[k * 8 + j] = d[lane * 8 + bsel];
				end
			end
		end
		return r;
	endfunction : cer_order_bits

	// presentation of the remainder on read
	function automatic cer_word_t cer_shape(input cer_word_t v, input logic refl, input logic swap);
		cer_word_t r;
		r = v;
		if (refl) begin
			for (int i = 0; i < 32; i++) begin
				r[i] = v[31 - i];
			end
		end
		if (swap) begin
			r = {r[7:0], r[15:8], r[23:16], r[31:24]};
		end
		return r;
	endfunction : cer_shape

	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	cer_addr_t aw_addr;
	logic aw_held;
	cer_word_t w_data;
	cer_strb_t w_strb;
	logic w_held;
	logic [4:0] control;
	cer_word_t poly;
	cer_word_t crc;
	cer_word_t seq;
	logic [5:0] bits_left;
	logic busy;
	cer_word_t next_crc;
	cer_word_t din_lane;
	logic [5:0] din_bits;
	logic write_go;
	logic din_go;

	assign write_go = aw_held && w_held && !s_axi_bvalid;
	assign din_lane = cer_lane_data(w_data, w_strb);
	assign din_bits = cer_strobe_bits(w_strb);
	// writes while busy or disabled are dropped rather than corrupting the fold
	assign din_go = write_go && aw_addr == CER_OFF_DATA_INPUT && control[CER_BIT_EN] && !busy
		&& din_bits != CER_BITS_NONE;

	// ---------------------------------------------------------------
	// write channel
	// ---------------------------------------------------------------
	// address and data are taken in either order; readies return after the response
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= 4'h0;
			w_data <= 32'h00000000;
			w_strb <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= CER_RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_addr <= s_axi_awaddr;
				aw_held <= 1'b1;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
				w_held <= 1'b1;
				s_axi_wready <= 1'b0;
			end
			if (write_go) begin
				aw_held <= 1'b0;
				w_held <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= cer_addr_ok(aw_addr) ? CER_RESP_OKAY : CER_RESP_SLVERR;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	// ---------------------------------------------------------------
	// control and polynomial registers
	// ---------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			control <= CER_CONTROL_RESET;
		end else if (write_go && aw_addr == CER_OFF_CONTROL && w_strb[0]) begin
			control <= w_data[CER_CONTROL_W-1:0];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			poly <= CER_POLY_RESET;
		end else if (write_go && aw_addr == CER_OFF_POLYNOMIAL) begin
			for (int b = 0; b < 4; b++) begin
				if (w_strb[b]) begin
					poly[b * 8 +: 8] <= w_data[b * 8 +: 8];
				end
			end
		end
	end

	// ---------------------------------------------------------------
	// crc engine, one bit per clock
	// ---------------------------------------------------------------
	cer_crc_step u_step (
		.crc_in(crc),
		.poly(poly),
		.data_bit(seq[0]),
		.msb_first(control[CER_BIT_MSB]),
		.crc_out(next_crc)
	);

	// result writes during a fold are dropped; the host only touches it idle
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			crc <= CER_RESULT_RESET;
			seq <= 32'h00000000;
			bits_left <= CER_BITS_NONE;
			busy <= 1'b0;
		end else if (din_go) begin
			seq <= cer_order_bits(din_lane, din_bits, control[CER_BIT_SWAP_IN], control[CER_BIT_MSB]);
			bits_left <= din_bits;
			busy <= 1'b1;
		end else if (busy) begin
			crc <= next_crc;
			seq <= {1'b0, seq[31:1]};
			bits_left <= bits_left - 6'h01;
			if (bits_left == 6'h01) begin
				busy <= 1'b0;
			end
		end else if (write_go && aw_addr == CER_OFF_RESULT) begin
			for (int b = 0; b < 4; b++) begin
				if (w_strb[b]) begin
					crc[b * 8 +: 8] <= w_data[b * 8 +: 8];
				end
			end
		end
	end

	assign crc_busy = busy;

	// ---------------------------------------------------------------
	// dma request
	// ---------------------------------------------------------------
	// dropped as soon as a data address is held so one request yields one word
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			dma_req <= 1'b0;
		end else begin
			dma_req <= control[CER_BIT_EN] && control[CER_BIT_DMA_EN] && !busy && !din_go
				&& !(aw_held && aw_addr == CER_OFF_DATA_INPUT);
		end
	end

	// ---------------------------------------------------------------
	// read channel
	// ---------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= CER_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= cer_addr_ok(s_axi_araddr) ? CER_RESP_OKAY : CER_RESP_SLVERR;
			case (s_axi_araddr)
				CER_OFF_CONTROL: s_axi_rdata <= 32'(control) | (32'(busy) << CER_BIT_BUSY);
				CER_OFF_POLYNOMIAL: s_axi_rdata <= poly;
				CER_OFF_RESULT: s_axi_rdata <= cer_shape(crc, control[CER_BIT_MSB],
					control[CER_BIT_SWAP_OUT]);
				default: s_axi_rdata <= 32'h00000000;
			endcase
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	// ---------------------------------------------------------------
	// assertions
	// ---------------------------------------------------------------
	default clocking cer_cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	logic ar_take;
	assign ar_take = s_axi_arvalid && s_axi_arready;

	sequence s_start(logic [5:0] n);
		din_go && din_bits == n;
	endsequence

	sequence s_busy_end;
		busy ##1 !busy;
	endsequence

	property p_byte_fold;
		s_start(CER_BITS_BYTE) |=> busy[*8] ##1 !busy;
	endproperty
	a_byte_fold: assert property (p_byte_fold) else $error("byte fold length wrong");

	property p_half_fold;
		s_start(CER_BITS_HALF) |=> busy ##15 s_busy_end;
	endproperty
	a_half_fold: assert property (p_half_fold) else $error("halfword fold length wrong");

	property p_word_fold;
		s_start(CER_BITS_WORD) |=> busy ##31 s_busy_end;
	endproperty
	a_word_fold: assert property (p_word_fold) else $error("word fold length wrong");

	property p_dma_after_done;
		control[CER_BIT_EN] && control[CER_BIT_DMA_EN] && $fell(busy) && !aw_held |=> dma_req;
	endproperty
	a_dma_after_done: assert property (p_dma_after_done) else $error("no dma request after fold");

	property p_reset_state;
		$rose(aresetn) |-> control == CER_CONTROL_RESET && !busy && !dma_req && poly == CER_POLY_RESET;
	endproperty
	a_reset_state: assert property (p_reset_state) else $error("bad state after reset");

	property p_reserved_zero;
		ar_take && s_axi_araddr == CER_OFF_CONTROL |=> s_axi_rdata[31:17] == 15'h0000
			&& s_axi_rdata[15:5] == 11'h000 && s_axi_rdata[CER_BIT_BUSY] == $past(busy);
	endproperty
	a_reserved_zero: assert property (p_reserved_zero) else $error("control read wrong");

	property p_result_shape;
		ar_take && s_axi_araddr == CER_OFF_RESULT |=> s_axi_rvalid
			&& s_axi_rdata == cer_shape($past(crc), $past(control[CER_BIT_MSB]), $past(control[CER_BIT_SWAP_OUT]));
	endproperty
	a_result_shape: assert property (p_result_shape) else $error("result shaping wrong");

	property p_input_read_quiet;
		ar_take && s_axi_araddr == CER_OFF_DATA_INPUT && !busy && !write_go |=> $stable(crc) && !busy;
	endproperty
	a_input_read_quiet: assert property (p_input_read_quiet) else $error("data read disturbed engine");

	property p_result_load;
		write_go && aw_addr == CER_OFF_RESULT && w_strb == 4'hf && !busy |=> crc == $past(w_data);
	endproperty
	a_result_load: assert property (p_result_load) else $error("result load lost");

	property p_swap_in_order;
		s_start(CER_BITS_HALF) ##0 (control[CER_BIT_SWAP_IN] && !control[CER_BIT_MSB])
			|=> seq[7:0] == $past(din_lane[15:8]);
	endproperty
	a_swap_in_order: assert property (p_swap_in_order) else $error("input byte order wrong");

	property p_msb_first;
		s_start(CER_BITS_BYTE) ##0 control[CER_BIT_MSB] |=> seq[0] == $past(din_lane[7]);
	endproperty
	a_msb_first: assert property (p_msb_first) else $error("bit order wrong");

endmodule : cer_top

`default_nettype wire

// File: rtl/cer_pkg.sv
// constants shared by the crc engine and its register bank
// assumes a 32-bit axi4-lite slave port with a 4-bit byte address
package cer_pkg;

	typedef logic [31:0] cer_word_t;
	typedef logic [3:0] cer_addr_t;
	typedef logic [3:0] cer_strb_t;
	typedef logic [1:0] cer_resp_t;

	// ---------------------------------------------------------------
	// register offsets
	// ---------------------------------------------------------------
	localparam cer_addr_t CER_OFF_CONTROL = 4'h0;
	localparam cer_addr_t CER_OFF_DATA_INPUT = 4'h4;
	localparam cer_addr_t CER_OFF_POLYNOMIAL = 4'h8;
	localparam cer_addr_t CER_OFF_RESULT = 4'hc;

	// ---------------------------------------------------------------
	// crc_control field positions
	// ---------------------------------------------------------------
	localparam int CER_BIT_EN = 0;
	localparam int CER_BIT_DMA_EN = 1;
	localparam int CER_BIT_MSB = 2;
	localparam int CER_BIT_SWAP_IN = 3;
	localparam int CER_BIT_SWAP_OUT = 4;
	localparam int CER_BIT_BUSY = 16;
	localparam int CER_CONTROL_W = 5;

	// ---------------------------------------------------------------
	// reset values
	// ---------------------------------------------------------------
	localparam logic [4:0] CER_CONTROL_RESET = 5'h00;
	localparam cer_word_t CER_POLY_RESET = 32'hedb88320;
	localparam cer_word_t CER_RESULT_RESET = 32'h00000000;

	// ---------------------------------------------------------------
	// bits per access width, one bit folded per clock
	// ---------------------------------------------------------------
	localparam logic [5:0] CER_BITS_NONE = 6'h00;
	localparam logic [5:0] CER_BITS_BYTE = 6'h08;
	localparam logic [5:0] CER_BITS_HALF = 6'h10;
	localparam logic [5:0] CER_BITS_WORD = 6'h20;

	localparam cer_resp_t CER_RESP_OKAY = 2'h0;
	localparam cer_resp_t CER_RESP_SLVERR = 2'h2;

endpackage : cer_pkg

// File: rtl/cer_crc_step.sv
// one-bit step of the crc generator, combinational
// assumes the caller registers the result and feeds one bit per clock
`timescale 1ns/1ns
`default_nettype none

module cer_crc_step (
	input wire cer_pkg::cer_word_t crc_in, // running remainder
	input wire cer_pkg::cer_word_t poly, // polynomial, top term implied
	input wire logic data_bit, // next data bit
	input wire logic msb_first, // 1: left-justified, shift left
	output cer_pkg::cer_word_t crc_out // remainder after this bit
);
	import cer_pkg::*;

	logic feedback;

	always_comb begin
		if (msb_first) begin
			// implied top term sits just above bit 31
			feedback = crc_in[31] ^ data_bit;
			crc_out = {crc_in[30:0], 1'b0} ^ (feedback ? poly : 32'h00000000);
		end else begin
			// reversed polynomial, implied term just below bit 0
			feedback = crc_in[0] ^ data_bit;
			crc_out = {1'b0, crc_in[31:1]} ^ (feedback ? poly : 32'h00000000);
		end
	end

endmodule : cer_crc_step

`default_nettype wire

// File: verification/cer_axi_host.sv
// axi4-lite master standing in for the processor and the dma controller
// assumes cer_top on the same clock; waits for every answer without a limit
`timescale 1ns/1ns
`default_nettype none

module cer_axi_host (
	input wire logic aclk, // bus clock
	output cer_pkg::cer_addr_t awaddr, // write address
	output logic awvalid, // write address valid
	input wire logic awready, // write address ready
	output cer_pkg::cer_word_t wdata, // write data
	output cer_pkg::cer_strb_t wstrb, // byte lanes
	output logic wvalid, // write data valid
	input wire logic wready, // write data ready
	input wire cer_pkg::cer_resp_t bresp, // write response
	input wire logic bvalid, // response valid
	output logic bready, // response ready
	output cer_pkg::cer_addr_t araddr, // read address
	output logic arvalid, // read address valid
	input wire logic arready, // read address ready
	input wire cer_pkg::cer_word_t rdata, // read data
	input wire cer_pkg::cer_resp_t rresp, // read response
	input wire logic rvalid, // read data valid
	output logic rready // read data ready
);
	import cer_pkg::*;

	initial begin
		awaddr = 4'h0;
		awvalid = 1'h0;
		wdata = 32'h0;
		wstrb = 4'h0;
		wvalid = 1'h0;
		bready = 1'h0;
		araddr = 4'h0;
		arvalid = 1'h0;
		rready = 1'h0;
	end

	// ---------------------------------------------------------------
	// bus cycles
	// ---------------------------------------------------------------
	// released payload is inverted so a stale value cannot pass for a held one
	task automatic do_write(input cer_addr_t a, input cer_word_t d, input cer_strb_t s, output cer_resp_t r);
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		do begin
			@(posedge aclk);
			if (awvalid && awready) begin
				awvalid <= 1'h0;
				awaddr <= ~a;
			end
			if (wvalid && wready) begin
				wvalid <= 1'h0;
				wdata <= ~d;
			end
		end while (!bvalid);
		bready <= 1'h0;
		r = bresp;
	endtask : do_write

	task automatic do_read(input cer_addr_t a, output cer_word_t d, output cer_resp_t r);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		do begin
			@(posedge aclk);
			if (arvalid && arready) begin
				arvalid <= 1'h0;
				araddr <= ~a;
			end
		end while (!rvalid);
		rready <= 1'h0;
		d = rdata;
		r = rresp;
	endtask : do_read
endmodule : cer_axi_host

`default_nettype wire

// File: verification/cer_top_bench.sv
// self-checking bench for the crc engine and its register bank
// assumes cer_axi_host as bus master, 50 MHz clock, fixed random seed
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin \
	tests_run++; \
	if ((g) !== (e)) begin \
		bad_count++; \
		$display("mismatch at %0t got %h expected %h", $time, g, e); \
	end \
end

module cer_top_bench;
	import cer_pkg::*;
	logic aclk = 1'h0;
	logic aresetn = 1'h0;
	cer_addr_t awaddr, araddr;
	cer_word_t wdata, rdata, poly, init, d0, d1, exp_val, got;
	cer_strb_t wstrb, strb;
	cer_resp_t bresp, rresp, resp;
	logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
	logic dma_req, crc_busy, msb, swi, swo, dma;
	int bad_count = 0;
	int tests_run = 0;
	int busy_len = 0;
	int last_len = 0;
	integer seed = 32'h877a02d8;
	cer_strb_t strb_tab [7] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'hc, 4'hf};

	cer_top i_cer_top (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .dma_req(dma_req), .crc_busy(crc_busy));

	cer_axi_host i_cer_axi_host (.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
		.bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
		.rresp(rresp), .rvalid(rvalid), .rready(rready));

	always #10 aclk = ~aclk;

	// busy length in cycles, latched when the flag drops
	always @(posedge aclk) begin
		if (!aresetn || crc_busy === 1'h1) begin
			busy_len <= aresetn ? busy_len + 1 : 0;
		end else if (busy_len != 0) begin
			last_len <= busy_len;
			busy_len <= 0;
		end
	end

	// ---------------------------------------------------------------
	// reference model
	// ---------------------------------------------------------------
	function automatic cer_word_t fold(cer_word_t c, cer_word_t p, cer_word_t d, cer_strb_t s, logic m, logic sw);
		logic [7:0] q[$];
		logic fb;
		for (int i = 0; i < 4; i++) begin
			if (s[i]) q.push_back(d[8*i+:8]);
		end
		if (sw) q.reverse();
		foreach (q[j]) begin
			for (int k = 0; k < 8; k++) begin
				fb = m ? (c[31] ^ q[j][7-k]) : (c[0] ^ q[j][k]);
				c = (m ? (c << 1) : (c >> 1)) ^ (fb ? p : 32'h0);
			end
		end
		return c;
	endfunction : fold

	function automatic cer_word_t shape(cer_word_t r, logic m, logic so);
		cer_word_t t;
		t = r;
		if (m) t = {<<{r}};
		if (so) t = {<<8{t}};
		return t;
	endfunction : shape

	task automatic wr(input cer_addr_t a, input cer_word_t d, input cer_strb_t s);
		i_cer_axi_host.do_write(a, d, s, resp);
	endtask : wr

	task automatic rd(input cer_addr_t a);
		i_cer_axi_host.do_read(a, got, resp);
	endtask : rd

	// host may touch the engine again only once busy is low
	task automatic wait_idle;
		int n;
		n = 0;
		while (crc_busy !== 1'h0 && n < 100) begin
			@(posedge aclk);
			n++;
		end
		// a fold that never ends counts against the run
		if (n >= 100) begin
			bad_count++;
		end
	endtask : wait_idle

	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : report_and_stop

	// ---------------------------------------------------------------
	// scenarios
	// ---------------------------------------------------------------
	initial begin
		#200000;
		bad_count++;
		report_and_stop();
	end

	initial begin
		repeat (8) @(posedge aclk);
		aresetn <= 1'h1;
		rd(CER_OFF_CONTROL);
		`CHK(got, 32'h00000000)
		rd(CER_OFF_POLYNOMIAL);
		`CHK(got, 32'hedb88320)
		rd(CER_OFF_RESULT);
		`CHK(got, 32'h00000000)
		wr(CER_OFF_CONTROL, 32'hffffffff, 4'hf);
		rd(CER_OFF_CONTROL);
		`CHK(got, 32'h0000001f)
		`CHK(dma_req, 1'h1)
		rd(4'h2);
		`CHK(resp, CER_RESP_SLVERR)
		wr(4'h6, 32'h0, 4'hf);
		`CHK(resp, CER_RESP_SLVERR)
		for (int i = 0; i < 16; i++) begin
			{dma, msb, swi, swo} = 4'(i);
			strb = strb_tab[i % 7];
			poly = $random(seed) | 32'h1;
			init = $random(seed);
			d0 = $random(seed);
			d1 = $random(seed);
			wr(CER_OFF_CONTROL, {27'h0, swo, swi, msb, dma, 1'h1}, 4'hf);
			wr(CER_OFF_POLYNOMIAL, poly, 4'hf);
			wr(CER_OFF_RESULT, init, 4'hf);
			wr(CER_OFF_DATA_INPUT, d0, strb);
			`CHK(crc_busy, 1'h1)
			`CHK(dma_req, 1'h0)
			rd(CER_OFF_DATA_INPUT);
			`CHK(got, 32'h0)
			wait_idle();
			rd(CER_OFF_DATA_INPUT);
			`CHK(got, 32'h0)
			exp_val = fold(init, poly, d0, strb, msb, swi);
			rd(CER_OFF_RESULT);
			`CHK(got, shape(exp_val, msb, swo))
			`CHK(last_len, 8 * $countones(strb))
			`CHK(dma_req, dma)
			wr(CER_OFF_DATA_INPUT, ~d1, 4'h5);
			wr(CER_OFF_DATA_INPUT, d1, 4'hf);
			wait_idle();
			exp_val = fold(exp_val, poly, d1, 4'hf, msb, swi);
			rd(CER_OFF_RESULT);
			`CHK(got, shape(exp_val, msb, swo))
		end
		wr(CER_OFF_CONTROL, 32'h0, 4'hf);
		wr(CER_OFF_DATA_INPUT, 32'h12345678, 4'hf);
		`CHK(crc_busy, 1'h0)
		rd(CER_OFF_RESULT);
		`CHK(got, exp_val)
		report_and_stop();
	end
endmodule : cer_top_bench

`default_nettype wire
